// >>> ccp_params.svh
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// Register port
`define ADDR_W 3
`define DATA_W 8
`define OFS_CONTROL 3'h0
`define OFS_CAP_SELECT 3'h1
`define OFS_VALUE_LOW 3'h2
`define OFS_VALUE_HIGH 3'h3
`define OFS_PERIOD 3'h4
`define READ_NONE 8'h00

// Control fields
`define CTL_EN 7
`define CTL_OUT 5
`define CTL_FMT 4
`define CTL_MODE 3:0
`define CAP_SEL 2:0
`define CAP_PAD 5'h00

// Reset values
`define RST_VALUE 8'h00
`define RST_PERIOD 8'hff

// Duty layout
`define DUTY_W 10
`define RIGHT_TOP 1:0
`define LEFT_BOTTOM 7:6
`define DUTY_ZERO 10'h000
`define BYTE_LOW 7:0
`define BYTE_HIGH 15:8

// Time bases
`define PWM_TIMER_W 8
`define PWM_SUB_W 2
`define CAP_DIV_W 4
`define CAP_DIV4_LAST 4'h3
`define CAP_DIV16_LAST 4'hf
`define TIMER16_W 16

`endif

// >>> ccp_pkg.sv
`default_nettype none

package ccp_pkg;

    typedef enum logic [3:0] {
        mode_off = 4'h0,
        cmp_toggle_clear = 4'h1,
        cmp_toggle = 4'h2,
        cap_every_edge = 4'h3,
        cap_falling = 4'h4,
        cap_rising = 4'h5,
        cap_rise4 = 4'h6,
        cap_rise16 = 4'h7,
        cmp_set = 4'h8,
        cmp_clear = 4'h9,
        cmp_pulse = 4'ha,
        cmp_pulse_clear = 4'hb,
        mode_rsv_c = 4'hc,
        mode_rsv_d = 4'hd,
        mode_rsv_e = 4'he,
        mode_pwm = 4'hf
    } mode_t;

    typedef enum logic [2:0] {
        src_pin = 3'h0,
        src_cmp_one = 3'h1,
        src_cmp_two = 3'h2,
        src_pin_change = 3'h3,
        src_cell_one = 3'h4,
        src_cell_two = 3'h5,
        src_cell_three = 3'h6,
        src_cell_four = 3'h7
    } cap_src_t;

endpackage

`default_nettype wire

// >>> capture_edge_detect.sv
`include "ccp_params.svh"
`default_nettype none

module capture_edge_detect
    import ccp_pkg::*;
#(
    parameter int DIV_W = `CAP_DIV_W
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic trig,
    input wire logic hold,
    input wire logic restart,
    input wire mode_t mode,
    output logic fire
);

    logic prev;
    logic [DIV_W-1:0] cnt;

    wire rise = trig && !prev;
    wire fall = !trig && prev;
    // Edge kind and prescale per capture mode
    wire edge_seen = (mode == cap_every_edge) ? (rise || fall) :
                     (mode == cap_falling) ? fall :
                     (mode == cap_rising || mode == cap_rise4 ||
                      mode == cap_rise16) ? rise : 1'b0;
    wire div_last = (mode == cap_rise4) ? (cnt == `CAP_DIV4_LAST) :
                    (mode == cap_rise16) ? (cnt == `CAP_DIV16_LAST) :
                    1'b1;

    assign fire = edge_seen && div_last && !hold && !restart;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev <= 1'b0;
            cnt <= '0;
        end
        else if (restart)
        begin
            prev <= trig;
            cnt <= '0;
        end
        else if (!hold && edge_seen)
        begin
            prev <= trig;
            cnt <= div_last ? '0 : cnt + 1'b1;
        end
        else if (!hold)
        begin
            prev <= trig;
        end
    end

endmodule

`default_nettype wire

// >>> pwm_timebase.sv
`include "ccp_params.svh"
`default_nettype none

module pwm_timebase #(
    parameter int TW = `PWM_TIMER_W,
    parameter int SW = `PWM_SUB_W
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic hold,
    input wire logic [TW-1:0] period,
    output logic [TW+SW-1:0] count,
    output logic rollover
);

    // Low bits count system clocks, so output rate follows sys_clk
    assign rollover = run && !hold && (count[TW+SW-1:SW] == period) &&
                      (&count[SW-1:0]);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= '0;
        end
        else if (!run)
        begin
            count <= '0;
        end
        else if (rollover)
        begin
            count <= '0;
        end
        else if (!hold)
        begin
            count <= count + 1'b1;
        end
    end

endmodule

`default_nettype wire

// >>> capture_compare_pwm_unit.sv
`include "ccp_params.svh"
`default_nettype none

module capture_compare_pwm_unit
    import ccp_pkg::*;
#(
    parameter int AW = `ADDR_W,
    parameter int DW = `DATA_W,
    parameter int TW16 = `TIMER16_W
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DW-1:0] reg_rdata,
    input wire logic sleep_active,
    input wire logic [TW16-1:0] sixteen_bit_base_timer,
    output logic sixteen_bit_timer_clear,
    input wire logic routed_input_pin,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic pin_change_event,
    input wire logic logic_cell_one_output,
    input wire logic logic_cell_two_output,
    input wire logic logic_cell_three_output,
    input wire logic logic_cell_four_output,
    input wire logic conversion_source_selected,
    output logic channel_event_flag,
    output logic conversion_trigger,
    output logic channel_pin_out,
    output logic channel_pin_drive_b
);

    localparam int PW = `PWM_TIMER_W + `PWM_SUB_W;

    logic ctl_en;
    logic ctl_fmt;
    mode_t mode;
    cap_src_t cap_sel;
    logic [DW-1:0] value_low;
    logic [DW-1:0] value_high;
    logic [`PWM_TIMER_W-1:0] period_value;
    logic [`DUTY_W-1:0] duty_buf;
    logic match_q;
    logic pulse_q;
    logic last_on;
    mode_t last_mode;
    logic cap_event;
    logic [PW-1:0] tb;
    logic tb_rollover;
    logic next_out;

    // Register port decode
    wire wr_control = reg_write && (reg_addr == `OFS_CONTROL);
    wire wr_cap_sel = reg_write && (reg_addr == `OFS_CAP_SELECT);
    wire wr_low = reg_write && (reg_addr == `OFS_VALUE_LOW);
    wire wr_high = reg_write && (reg_addr == `OFS_VALUE_HIGH);
    wire wr_period = reg_write && (reg_addr == `OFS_PERIOD);

    // Mode decode
    wire ch_on = ctl_en && (mode != mode_off);
    wire restart = !ch_on || !last_on || (mode != last_mode);
    wire is_pwm = ch_on && (mode == mode_pwm);
    wire is_capture = ch_on && (mode inside {cap_every_edge, cap_falling,
                                cap_rising, cap_rise4, cap_rise16});
    wire is_compare = ch_on && (mode inside {cmp_toggle_clear, cmp_toggle,
                                cmp_set, cmp_clear, cmp_pulse,
                                cmp_pulse_clear});
    wire pulse_mode = (mode == cmp_pulse) || (mode == cmp_pulse_clear);
    wire clears_timer = (mode == cmp_pulse_clear) ||
                        (mode == cmp_toggle_clear);

    // Capture source routing
    wire [7:0] trig_vec = {logic_cell_four_output, logic_cell_three_output,
                           logic_cell_two_output, logic_cell_one_output,
                           pin_change_event, comparator_two_output,
                           comparator_one_output, routed_input_pin};
    wire cap_trigger = trig_vec[cap_sel];

    capture_edge_detect #(.DIV_W(`CAP_DIV_W)) u_edge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .trig(cap_trigger),
        .hold(sleep_active),
        .restart(restart || !is_capture),
        .mode(mode),
        .fire(cap_event)
    );

    // Compare: one hit per entry into the match condition
    wire [TW16-1:0] value_pair = {value_high, value_low};
    wire cmp_equal = is_compare &&
                     (value_pair == sixteen_bit_base_timer);
    wire cmp_hit = cmp_equal && !match_q && !sleep_active && !restart;

    // Duty layout
    wire [`DUTY_W-1:0] duty_right = {value_high[`RIGHT_TOP], value_low};
    wire [`DUTY_W-1:0] duty_left = {value_high, value_low[`LEFT_BOTTOM]};
    wire [`DUTY_W-1:0] duty_value = ctl_fmt ? duty_left : duty_right;

    pwm_timebase #(.TW(`PWM_TIMER_W), .SW(`PWM_SUB_W)) u_timebase (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(is_pwm),
        .hold(sleep_active),
        .period(period_value),
        .count(tb),
        .rollover(tb_rollover)
    );

    // One count ahead, so the pin is already low while tb equals duty
    wire [PW-1:0] tb_next = tb + 1'b1;
    wire duty_hit = is_pwm && !sleep_active && (tb_next == duty_buf);
    wire any_event = cap_event || cmp_hit || duty_hit;

    // Hardware capture wins over a software write in the same cycle
    wire [DW-1:0] next_value_low =
        cap_event ? sixteen_bit_base_timer[`BYTE_LOW] :
        wr_low ? reg_wdata : value_low;
    wire [DW-1:0] next_value_high =
        cap_event ? sixteen_bit_base_timer[`BYTE_HIGH] :
        wr_high ? reg_wdata : value_high;

    // Output level
    always_comb
    begin
        next_out = channel_pin_out;
        if (restart)
        begin
            next_out = 1'b0;
        end
        else if (sleep_active)
        begin
            next_out = channel_pin_out;
        end
        else if (is_pwm)
        begin
            if (tb_rollover)
            begin
                next_out = (duty_value != `DUTY_ZERO);
            end
            else if (duty_hit)
            begin
                next_out = 1'b0;
            end
        end
        else if (pulse_q)
        begin
            next_out = 1'b0;
        end
        else if (cmp_hit)
        begin
            case (mode)
                cmp_set: next_out = 1'b1;
                cmp_clear: next_out = 1'b0;
                cmp_pulse: next_out = 1'b1;
                cmp_pulse_clear: next_out = 1'b1;
                cmp_toggle: next_out = !channel_pin_out;
                cmp_toggle_clear: next_out = !channel_pin_out;
                default: next_out = channel_pin_out;
            endcase
        end
    end

    wire next_drive_b = sleep_active ? channel_pin_drive_b :
                        !(is_pwm || is_compare);
    wire next_pulse_q = restart ? 1'b0 :
                        sleep_active ? pulse_q : (cmp_hit && pulse_mode);
    wire next_match_q = sleep_active ? match_q : cmp_equal;

    // Read path
    wire [DW-1:0] rd_control = {ctl_en, 1'b0, channel_pin_out,
                                ctl_fmt, mode};
    wire [DW-1:0] rd_cap_sel = {`CAP_PAD, cap_sel};
    wire [DW-1:0] next_rdata =
        !reg_read ? `READ_NONE :
        (reg_addr == `OFS_CONTROL) ? rd_control :
        (reg_addr == `OFS_CAP_SELECT) ? rd_cap_sel :
        (reg_addr == `OFS_VALUE_LOW) ? value_low :
        (reg_addr == `OFS_VALUE_HIGH) ? value_high :
        (reg_addr == `OFS_PERIOD) ? period_value : `READ_NONE;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_en <= 1'b0;
            ctl_fmt <= 1'b0;
            mode <= mode_off;
            cap_sel <= src_pin;
            period_value <= `RST_PERIOD;
        end
        else
        begin
            if (wr_control)
            begin
                ctl_en <= reg_wdata[`CTL_EN];
                ctl_fmt <= reg_wdata[`CTL_FMT];
                mode <= mode_t'(reg_wdata[`CTL_MODE]);
            end
            if (wr_cap_sel)
            begin
                cap_sel <= cap_src_t'(reg_wdata[`CAP_SEL]);
            end
            if (wr_period)
            begin
                period_value <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            value_low <= `RST_VALUE;
            value_high <= `RST_VALUE;
            reg_rdata <= `READ_NONE;
        end
        else
        begin
            value_low <= next_value_low;
            value_high <= next_value_high;
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            duty_buf <= `DUTY_ZERO;
        end
        else if (restart || tb_rollover)
        begin
            duty_buf <= restart ? `DUTY_ZERO : duty_value;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            channel_pin_out <= 1'b0;
            channel_pin_drive_b <= 1'b1;
            match_q <= 1'b0;
            pulse_q <= 1'b0;
            last_on <= 1'b0;
            last_mode <= mode_off;
        end
        else
        begin
            channel_pin_out <= next_out;
            channel_pin_drive_b <= next_drive_b;
            match_q <= next_match_q;
            pulse_q <= next_pulse_q;
            last_on <= ch_on;
            last_mode <= mode;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sixteen_bit_timer_clear <= 1'b0;
            channel_event_flag <= 1'b0;
            conversion_trigger <= 1'b0;
        end
        else
        begin
            sixteen_bit_timer_clear <= cmp_hit && clears_timer;
            channel_event_flag <= any_event;
            conversion_trigger <= any_event && conversion_source_selected;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sleep_timer_hold_a: assert property (
        sleep_active && !reg_write |=> $stable(tb) && $stable(duty_buf))
        else $error("pulse timer moved during sleep");
    sleep_pin_hold_a: assert property (
        sleep_active && !reg_write |=> $stable(channel_pin_out) &&
            $stable(channel_pin_drive_b))
        else $error("pin changed during sleep");
    wake_resume_a: assert property (
        !sleep_active && $past(sleep_active) && is_pwm && !tb_rollover &&
            !reg_write |=> tb == $past(tb) + 1'b1)
        else $error("pulse timer did not resume from held count");
    control_read_a: assert property (
        reg_read && reg_addr == `OFS_CONTROL |=>
            reg_rdata[`CTL_OUT] == $past(channel_pin_out) &&
            reg_rdata[`CTL_EN] == $past(ctl_en) && !reg_rdata[6])
        else $error("control read back wrong");
    capture_latch_a: assert property (
        cap_event |=> value_pair == $past(sixteen_bit_base_timer) ##0
            channel_event_flag)
        else $error("capture did not latch timer");
    compare_set_a: assert property (
        cmp_hit && mode == cmp_set |=> channel_pin_out)
        else $error("set on match failed");
    compare_pulse_a: assert property (
        cmp_hit && pulse_mode && !reg_write ##1 !sleep_active && !restart
            |-> channel_pin_out ##1 !channel_pin_out)
        else $error("match pulse shape wrong");
    timer_clear_a: assert property (
        cmp_hit && clears_timer |=> sixteen_bit_timer_clear ##1
            !sixteen_bit_timer_clear)
        else $error("base timer clear pulse wrong");
    period_load_a: assert property (
        tb_rollover && !restart && duty_value != `DUTY_ZERO |=>
            channel_pin_out && duty_buf == $past(duty_value) &&
            tb == '0)
        else $error("period end handling wrong");
    duty_clear_a: assert property (
        duty_hit && !tb_rollover && !restart |=> !channel_pin_out)
        else $error("duty match did not drive low");
    off_state_a: assert property (
        !ch_on && !reg_write |=> !channel_pin_out ##0
            channel_pin_drive_b)
        else $error("channel off but pin active");

    capture_seen_c: cover property (cap_event);
    pulse_seen_c: cover property (cmp_hit && pulse_mode ##2
        !channel_pin_out);
    pwm_cycle_c: cover property (duty_hit ##[1:40] tb_rollover);
    wake_seen_c: cover property (is_pwm && sleep_active ##1
        !sleep_active);

endmodule

`default_nettype wire

// >>> base_timer_model.sv
`default_nettype none

// Far-side 16-bit counter that the channel captures from and compares with
module base_timer_model
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic clear,
    output logic [15:0] count
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clear from the channel beats counting
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= 16'h0000;
        else if (load)
            count <= load_val;
        else if (clear)
            count <= 16'h0000;
        else if (run)
            count <= count + 16'h0001;
    end
endmodule

`default_nettype wire

// >>> capture_compare_pwm_unit_tb.sv
`include "ccp_params.svh"
`default_nettype none

module capture_compare_pwm_unit_tb
    import ccp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHECK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("wrong value at %0t ns: %h, expected %h", \
                $time, got, exp); \
        end \
    end

    typedef struct {
        logic pin;
        logic clr;
        logic conv;
        bit pin_chk;
    } note_t;

    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic sleep_active = 1'b0;
    logic [7:0] src = 8'h00;
    logic conv_sel = 1'b0;
    logic tmr_run = 1'b0;
    logic tmr_load = 1'b0;
    logic [15:0] tmr_val = 16'h0000;
    logic [7:0] reg_rdata;
    logic [15:0] base_timer;
    logic timer_clear;
    logic event_flag;
    logic conv_trig;
    logic pin_out;
    logic pin_drive_b;
    int fails = 0;
    int samples_checked = 0;
    int pwm_ev = 0;
    bit pwm_phase = 1'b0;
    bit rd_seen = 1'b0;
    logic [7:0] rd_q[$];
    note_t ev_q[$];
    note_t ev_n;
    logic [7:0] rd_e;
    mode_t cap_modes[5] = '{cap_rising, cap_falling, cap_every_edge,
        cap_rise4, cap_rise16};
    int cap_counts[5] = '{16, 16, 32, 4, 1};
    mode_t cmp_modes[9] = '{cmp_set, cmp_clear, cmp_toggle,
        cmp_toggle_clear, cmp_pulse, cmp_pulse_clear, mode_rsv_c,
        mode_rsv_d, mode_rsv_e};
    bit [0:8] cmp_hit = 9'b101111000;
    bit [0:8] cmp_clr = 9'b000101000;
    bit [0:8] cmp_fin = 9'b101100000;

    always #2.5 sys_clk = ~sys_clk;

    capture_compare_pwm_unit i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sleep_active(sleep_active),
        .sixteen_bit_base_timer(base_timer),
        .sixteen_bit_timer_clear(timer_clear),
        .routed_input_pin(src[0]), .comparator_one_output(src[1]),
        .comparator_two_output(src[2]), .pin_change_event(src[3]),
        .logic_cell_one_output(src[4]), .logic_cell_two_output(src[5]),
        .logic_cell_three_output(src[6]), .logic_cell_four_output(src[7]),
        .conversion_source_selected(conv_sel),
        .channel_event_flag(event_flag), .conversion_trigger(conv_trig),
        .channel_pin_out(pin_out), .channel_pin_drive_b(pin_drive_b)
    );

    base_timer_model i_timer (
        .sys_clk(sys_clk), .rst_b(rst_b), .run(tmr_run), .load(tmr_load),
        .load_val(tmr_val), .clear(timer_clear), .count(base_timer)
    );

    // Result watcher, sampled mid-cycle
    always @(negedge sys_clk)
    begin
        if (rd_seen)
        begin
            rd_e = rd_q.pop_front();
            `CHECK(reg_rdata, rd_e)
        end
        rd_seen = reg_read;
        if (event_flag === 1'b1 && pwm_phase)
            pwm_ev++;
        else if (event_flag === 1'b1)
        begin
            `CHECK(ev_q.size() > 0, 1'b1)
            if (ev_q.size() > 0)
            begin
                ev_n = ev_q.pop_front();
                `CHECK(conv_trig, ev_n.conv)
                `CHECK(timer_clear, ev_n.clr)
                if (ev_n.pin_chk)
                    `CHECK(pin_out, ev_n.pin)
            end
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
    endtask

    task automatic load_timer(input logic [15:0] v);
        @(posedge sys_clk);
        tmr_val <= v;
        tmr_load <= 1'b1;
        @(posedge sys_clk);
        tmr_load <= 1'b0;
    endtask

    task automatic pulse(input int idx);
        @(posedge sys_clk);
        src[idx] <= 1'b1;
        idle(2);
        src[idx] <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic expect_ev(input logic p, input logic c, input bit k);
        ev_q.push_back('{p, c, conv_sel, k});
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic chk_regs();
        rd(`OFS_CONTROL, 8'h00);
        rd(`OFS_CAP_SELECT, 8'h00);
        rd(`OFS_VALUE_LOW, `RST_VALUE);
        rd(`OFS_VALUE_HIGH, `RST_VALUE);
        rd(`OFS_PERIOD, `RST_PERIOD);
        rd(3'h5, `READ_NONE);
        @(negedge sys_clk);
        `CHECK(pin_drive_b, 1'b1)
    endtask

    // High cycles and events over four periods from a rising edge
    task automatic pwm_check(input int hi, input int evn, input bit nap);
        int seen;
        int ev0;
        int k;
        logic held;
        bit napping;
        seen = 0;
        k = 0;
        napping = 1'b0;
        held = 1'b0;
        idle(40);
        @(negedge sys_clk);
        while (hi > 0 && pin_out !== 1'b0 && k++ < 100)
            @(negedge sys_clk);
        while (hi > 0 && pin_out !== 1'b1 && k++ < 100)
            @(negedge sys_clk);
        ev0 = pwm_ev;
        k = 0;
        fork
            if (nap)
            begin
                idle(50);
                sleep_active <= 1'b1;
                idle(9);
                sleep_active <= 1'b0;
            end
        join_none
        while (k < 128)
        begin
            if (sleep_active === 1'b1)
            begin
                if (!napping)
                    held = pin_out;
                napping = 1'b1;
                `CHECK(pin_out, held)
            end
            else
            begin
                seen += (pin_out === 1'b1);
                k++;
            end
            @(negedge sys_clk);
        end
        `CHECK(seen, hi)
        if (evn >= 0)
            `CHECK(pwm_ev - ev0, evn)
    endtask

    task automatic stop_test();
        $display("checked %0d values, %0d wrong", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        stop_test();
    end

    initial
    begin
        logic [15:0] v;
        void'($urandom(32'h0a97cd71));
        idle(5);
        rst_b <= 1'b1;
        chk_regs();
        done("reset values");
        v = 16'($urandom);
        wr(`OFS_VALUE_LOW, v[7:0]);
        wr(`OFS_VALUE_HIGH, v[15:8]);
        wr(`OFS_CAP_SELECT, 8'hff);
        wr(`OFS_CONTROL, 8'h7c);
        wr(3'h6, 8'h5a);
        rd(`OFS_VALUE_LOW, v[7:0]);
        rd(`OFS_VALUE_HIGH, v[15:8]);
        rd(`OFS_CAP_SELECT, 8'h07);
        rd(`OFS_CONTROL, 8'h1c);
        rd(3'h6, `READ_NONE);
        done("register access");
        v = 16'($urandom);
        load_timer(v);
        wr(`OFS_CAP_SELECT, 8'h00);
        foreach (cap_modes[i])
        begin
            wr(`OFS_CONTROL, {4'h8, cap_modes[i]});
            idle(3);
            repeat (cap_counts[i]) expect_ev(1'b0, 1'b0, 1'b0);
            repeat (16) pulse(0);
            idle(3);
            `CHECK(ev_q.size(), 0)
        end
        rd(`OFS_VALUE_LOW, v[7:0]);
        rd(`OFS_VALUE_HIGH, v[15:8]);
        done("capture prescale");
        wr(`OFS_CONTROL, {4'h8, cap_rising});
        for (int s = 0; s < 8; s++)
        begin
            wr(`OFS_CAP_SELECT, 8'(s));
            conv_sel <= s[0];
            idle(2);
            pulse((s + 1) % 8);
            expect_ev(1'b0, 1'b0, 1'b0);
            pulse(s);
            idle(2);
            `CHECK(ev_q.size(), 0)
        end
        done("capture source");
        foreach (cmp_modes[i])
        begin
            v = 16'h0010 + 16'($urandom_range(16'hff00));
            load_timer(v);
            v = v + 16'h0005;
            wr(`OFS_VALUE_LOW, v[7:0]);
            wr(`OFS_VALUE_HIGH, v[15:8]);
            wr(`OFS_CONTROL, {4'h8, cmp_modes[i]});
            idle(3);
            if (i < 6)
                expect_ev(cmp_hit[i], cmp_clr[i], 1'b1);
            tmr_run <= 1'b1;
            idle(12);
            tmr_run <= 1'b0;
            idle(3);
            @(negedge sys_clk);
            `CHECK(pin_drive_b, logic'(i >= 6))
            `CHECK(ev_q.size(), 0)
            rd(`OFS_CONTROL, {2'b10, cmp_fin[i], 1'b0, cmp_modes[i]});
        end
        done("compare modes");
        pwm_phase = 1'b1;
        wr(`OFS_PERIOD, 8'h07);
        wr(`OFS_VALUE_HIGH, 8'h00);
        wr(`OFS_VALUE_LOW, 8'h0c);
        wr(`OFS_CONTROL, 8'h8f);
        pwm_check(48, 4, 1'b0);
        wr(`OFS_CONTROL, 8'h9f);
        pwm_check(0, -1, 1'b0);
        wr(`OFS_VALUE_HIGH, 8'h02);
        wr(`OFS_VALUE_LOW, 8'hc0);
        pwm_check(44, 4, 1'b0);
        pwm_check(44, -1, 1'b1);
        done("pulse width");
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(negedge sys_clk);
        `CHECK(pin_drive_b, 1'b1)
        `CHECK(pin_out, 1'b0)
        idle(5);
        rst_b <= 1'b1;
        pwm_phase = 1'b0;
        chk_regs();
        wr(`OFS_CONTROL, {4'h8, cmp_set});
        wr(`OFS_CONTROL, 8'h80);
        idle(3);
        @(negedge sys_clk);
        `CHECK(pin_drive_b, 1'b1)
        rd(`OFS_CONTROL, 8'h80);
        done("reset and off");
        idle(3);
        stop_test();
    end
endmodule

`default_nettype wire
